// *** core/det_count_clock.sv ***
/*
 * Count-clock selector for one channel: event edge or a power-of-two
 * division of pclk, emitted as a one-cycle tick.
 * Assumes edge pulses come from det_event_sync.
 */
`timescale 1ns/1ps
`include "det_params.svh"

module det_count_clock
    import det_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    // selection
    input wire logic [3:0] sel,
    input wire logic clock_scale_bit,
    input wire logic run,
    // event edges and tick
    input wire logic evt_rise,
    input wire logic evt_fall,
    output logic tick
);

    det_clk_st_t cur_r, cur_nxt;
    logic [3:0] exp_w;
    logic [11:0] mask_w;
    logic div_sel_w;

    always_comb begin
        cur_nxt = cur_r;
        exp_w = 4'h0;
        div_sel_w = 1'b0;
        cur_nxt.tick = 1'b0;
        case (sel)
            `DET_SEL_EVT_FALL: cur_nxt.tick = evt_fall;
            `DET_SEL_EVT_RISE: cur_nxt.tick = evt_rise;
            `DET_SEL_DIV_TOP: begin
                exp_w = `DET_EXP_TOP;
                div_sel_w = 1'b1;
            end
            default: begin
                // prohibited codes never tick
                if (sel >= `DET_SEL_DIV_FIRST && sel <= `DET_SEL_DIV_LAST) begin
                    exp_w = sel - `DET_EXP_BASE;
                    div_sel_w = 1'b1;
                end
            end
        endcase
        // scale bit low doubles every divided period
        if (!clock_scale_bit) begin
            exp_w = exp_w + 4'h1;
        end
        mask_w = ~(12'hFFF << exp_w);
        if (div_sel_w && ((cur_r.div & mask_w) == mask_w)) begin
            cur_nxt.tick = 1'b1;
        end
        cur_nxt.div = cur_r.div + 12'h001;
        // a stopped channel restarts with a whole first period
        if (!run) begin
            cur_nxt.div = 12'h000;
            cur_nxt.tick = 1'b0;
        end
        tick = cur_r.tick;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_r <= '0;
        end else if (pce) begin
            cur_r <= cur_nxt;
        end
    end

endmodule

// *** core/det_event_sync.sv ***
/*
 * Two-flop synchroniser and edge detector for one event pin.
 * Assumes the pin is asynchronous to pclk and pulses wider than two
 * clock periods in each level.
 */
`timescale 1ns/1ps

module det_event_sync
    import det_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    // event pin and detected edges
    input wire logic pin,
    output logic rise,
    output logic fall
);

    det_sync_st_t cur_r, cur_nxt;

    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.s1 = pin;
        cur_nxt.s2 = cur_r.s1;
        cur_nxt.s3 = cur_r.s2;
        // only s2 and s3 feed the edge logic, s1 stays private
        rise = cur_r.s2 & ~cur_r.s3;
        fall = ~cur_r.s2 & cur_r.s3;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_r <= '0;
        end else if (pce) begin
            cur_r <= cur_nxt;
        end
    end

endmodule

// *** core/det_timer.sv ***
/*
 * Dual 8-bit timer / event counter with APB register access, compare
 * match interrupts and square-wave outputs.
 * Assumes a single pclk domain, APB master per AMBA, and that software
 * routes the wave pins to the pads before enabling them.
 */
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`include "det_params.svh"

module det_timer
    import det_pkg::*;
(
    // clock, reset, clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event pins
    input wire logic ch1_event_in,
    input wire logic ch2_event_in,
    // wave pins
    output logic ch1_wave_out,
    output logic ch1_wave_oe,
    output logic ch2_wave_out,
    output logic ch2_wave_oe,
    // interrupts
    output logic ch1_match_irq,
    output logic ch2_match_irq,
    output logic irq
);

    det_top_st_t cur_r, cur_nxt;

    logic ch1_rise, ch1_fall, ch2_rise, ch2_fall;
    logic ch1_tick, ch2_tick;
    logic [31:0] rd_data;
    logic rd_err;
    logic wr_go;
    logic [8:0] step1, step2;
    logic [1:0] sts_clr;

    // ------------------------------------------------------------------
    // one counter step: bit 8 flags a compare match
    // ------------------------------------------------------------------
    function automatic logic [8:0] chan_step(
        input logic [7:0] cnt,
        input logic [7:0] cmp,
        input logic tick,
        input logic run
    );
        logic [8:0] res;
        res = {1'b0, cnt};
        if (!run) begin
            res = 9'h000;
        end else if (tick) begin
            if (cnt == cmp) begin
                // cleared to zero, counting goes on
                res = 9'h100;
            end else begin
                res = {1'b0, 8'(cnt + 8'h01)};
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // event pins and count clocks
    // ------------------------------------------------------------------
    det_event_sync u_ch1_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .pin(ch1_event_in),
        .rise(ch1_rise),
        .fall(ch1_fall)
    );

    det_event_sync u_ch2_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .pin(ch2_event_in),
        .rise(ch2_rise),
        .fall(ch2_fall)
    );

    det_count_clock u_ch1_clk (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .sel(cur_r.count_clock_select_reg[`DET_SEL_CH1_LSB +: 4]),
        .clock_scale_bit(cur_r.clock_scale_bit),
        .run(cur_r.run[0]),
        .evt_rise(ch1_rise),
        .evt_fall(ch1_fall),
        .tick(ch1_tick)
    );

    det_count_clock u_ch2_clk (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .sel(cur_r.count_clock_select_reg[`DET_SEL_CH2_LSB +: 4]),
        .clock_scale_bit(cur_r.clock_scale_bit),
        .run(cur_r.run[1]),
        .evt_rise(ch2_rise),
        .evt_fall(ch2_fall),
        .tick(ch2_tick)
    );

    // ------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = `DET_RST_WORD;
        rd_err = 1'b0;
        case (paddr)
            `DET_ADDR_CLK_SEL: rd_data[7:0] = cur_r.count_clock_select_reg;
            `DET_ADDR_OUT_CTRL: begin
                // level set and reset bits always read zero
                rd_data[`DET_OC_OE1] = cur_r.ch1_output_enable;
                rd_data[`DET_OC_OE2] = cur_r.ch2_output_enable;
            end
            `DET_ADDR_OSC_SEL: rd_data[`DET_OSC_SCALE] = cur_r.clock_scale_bit;
            `DET_ADDR_CMP1: rd_data[7:0] = cur_r.ch1_compare;
            `DET_ADDR_CMP2: rd_data[7:0] = cur_r.ch2_compare;
            `DET_ADDR_CNT1: rd_data[7:0] = cur_r.ch1_counter;
            `DET_ADDR_CNT2: rd_data[7:0] = cur_r.ch2_counter;
            `DET_ADDR_RUN: rd_data[1:0] = cur_r.run;
            `DET_ADDR_IRQ_STS: rd_data[1:0] = cur_r.sts;
            `DET_ADDR_IRQ_MSK: rd_data[1:0] = cur_r.msk;
            default: rd_err = 1'b1;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        cur_nxt = cur_r;
        wr_go = 1'b0;
        sts_clr = 2'b00;

        // bus: one wait state, then the access completes
        case (cur_r.bus)
            DET_BUS_IDLE: begin
                cur_nxt.pready = 1'b0;
                cur_nxt.pslverr = 1'b0;
                if (psel && penable) begin
                    cur_nxt.bus = DET_BUS_ACK;
                    cur_nxt.pready = 1'b1;
                    cur_nxt.pslverr = rd_err;
                    cur_nxt.prdata = pwrite ? `DET_RST_WORD : rd_data;
                end
            end
            DET_BUS_ACK: begin
                cur_nxt.bus = DET_BUS_IDLE;
                cur_nxt.pready = 1'b0;
                cur_nxt.pslverr = 1'b0;
                wr_go = psel && penable && pwrite && !cur_r.pslverr;
            end
            default: begin
                cur_nxt.bus = DET_BUS_IDLE;
                cur_nxt.pready = 1'b0;
                cur_nxt.pslverr = 1'b0;
            end
        endcase

        // counters
        step1 = chan_step(cur_r.ch1_counter, cur_r.ch1_compare, ch1_tick, cur_r.run[0]);
        step2 = chan_step(cur_r.ch2_counter, cur_r.ch2_compare, ch2_tick, cur_r.run[1]);
        cur_nxt.ch1_counter = step1[7:0];
        cur_nxt.ch2_counter = step2[7:0];
        cur_nxt.ch1_match = step1[8];
        cur_nxt.ch2_match = step2[8];
        if (step1[8] && cur_r.ch1_output_enable) begin
            cur_nxt.ch1_wave = ~cur_r.ch1_wave;
        end
        if (step2[8] && cur_r.ch2_output_enable) begin
            cur_nxt.ch2_wave = ~cur_r.ch2_wave;
        end

        // register writes
        if (wr_go) begin
            case (paddr)
                `DET_ADDR_CLK_SEL: cur_nxt.count_clock_select_reg = pwdata[7:0];
                `DET_ADDR_OUT_CTRL: begin
                    cur_nxt.ch1_output_enable = pwdata[`DET_OC_OE1];
                    cur_nxt.ch2_output_enable = pwdata[`DET_OC_OE2];
                    // reset wins if both level bits are written as one
                    if (pwdata[`DET_OC_CH1_LEVEL_RESET]) begin
                        cur_nxt.ch1_wave = 1'b0;
                    end else if (pwdata[`DET_OC_CH1_LEVEL_SET]) begin
                        cur_nxt.ch1_wave = 1'b1;
                    end
                    if (pwdata[`DET_OC_LVR2]) begin
                        cur_nxt.ch2_wave = 1'b0;
                    end else if (pwdata[`DET_OC_LVS2]) begin
                        cur_nxt.ch2_wave = 1'b1;
                    end
                end
                `DET_ADDR_OSC_SEL: cur_nxt.clock_scale_bit = pwdata[`DET_OSC_SCALE];
                `DET_ADDR_CMP1: cur_nxt.ch1_compare = pwdata[7:0];
                `DET_ADDR_CMP2: cur_nxt.ch2_compare = pwdata[7:0];
                `DET_ADDR_RUN: cur_nxt.run = pwdata[1:0];
                `DET_ADDR_IRQ_STS: sts_clr = pwdata[1:0];
                `DET_ADDR_IRQ_MSK: cur_nxt.msk = pwdata[1:0];
                default: sts_clr = 2'b00;
            endcase
        end

        // a match in the clearing cycle keeps its status bit
        cur_nxt.sts = (cur_r.sts & ~sts_clr) | {step2[8], step1[8]};
        cur_nxt.irq = |(cur_nxt.sts & cur_nxt.msk);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_r <= '0;
            cur_r.bus <= DET_BUS_IDLE;
        end else if (pce) begin
            cur_r <= cur_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign prdata = cur_r.prdata;
    assign pready = cur_r.pready;
    assign pslverr = cur_r.pslverr;
    assign ch1_wave_out = cur_r.ch1_wave;
    assign ch2_wave_out = cur_r.ch2_wave;
    assign ch1_wave_oe = cur_r.ch1_output_enable;
    assign ch2_wave_oe = cur_r.ch2_output_enable;
    assign ch1_match_irq = cur_r.ch1_match;
    assign ch2_match_irq = cur_r.ch2_match;
    assign irq = cur_r.irq;

endmodule

// *** shared/det_params.svh ***
/*
 * Register offsets, field positions, reset values and count-clock codes
 * of the dual event timer.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DET_PARAMS_SVH
`define DET_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define DET_ADDR_CLK_SEL 12'h000
`define DET_ADDR_OUT_CTRL 12'h004
`define DET_ADDR_OSC_SEL 12'h008
`define DET_ADDR_CMP1 12'h00C
`define DET_ADDR_CMP2 12'h010
`define DET_ADDR_CNT1 12'h014
`define DET_ADDR_CNT2 12'h018
`define DET_ADDR_RUN 12'h01C
`define DET_ADDR_IRQ_STS 12'h020
`define DET_ADDR_IRQ_MSK 12'h024

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DET_SEL_CH1_LSB 0
`define DET_SEL_CH2_LSB 4
`define DET_OC_OE1 0
`define DET_OC_CH1_LEVEL_SET 2
`define DET_OC_CH1_LEVEL_RESET 3
`define DET_OC_OE2 4
`define DET_OC_LVS2 6
`define DET_OC_LVR2 7
`define DET_OSC_SCALE 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DET_RST_BYTE 8'h00
`define DET_RST_WORD 32'h0000_0000

// ----------------------------------------------------------------------
// count-clock select codes; divide ratio is 2 to the exponent while clock_scale_bit is high
// ----------------------------------------------------------------------
`define DET_SEL_EVT_FALL 4'h0
`define DET_SEL_EVT_RISE 4'h1
`define DET_SEL_DIV_FIRST 4'h6
`define DET_SEL_DIV_LAST 4'hE
`define DET_SEL_DIV_TOP 4'hF
`define DET_EXP_BASE 4'h5
`define DET_EXP_TOP 4'hB

`endif

// *** shared/det_pkg.sv ***
/*
 * Types of the dual event timer: bus states and the packed state
 * records of each module.
 * Assumes det_params.svh is compiled alongside.
 */
package det_pkg;

    typedef enum logic [1:0] {
        DET_BUS_IDLE = 2'b01,
        DET_BUS_ACK = 2'b10
    } det_bus_st_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } det_sync_st_t;

    typedef struct packed {
        logic [11:0] div;
        logic tick;
    } det_clk_st_t;

    typedef struct packed {
        det_bus_st_t bus;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] count_clock_select_reg;
        logic clock_scale_bit;
        logic [1:0] run;
        logic [7:0] ch1_compare;
        logic [7:0] ch2_compare;
        logic [7:0] ch1_counter;
        logic [7:0] ch2_counter;
        logic ch1_output_enable;
        logic ch2_output_enable;
        logic ch1_wave;
        logic ch2_wave;
        logic ch1_match;
        logic ch2_match;
        logic [1:0] sts;
        logic [1:0] msk;
        logic irq;
    } det_top_st_t;

endpackage

// *** sim/det_evt_src.sv ***
/*
 * External event pulse source for one event pin.
 * Assumes the bench clock; the pin rests at idle between pulses.
 */
`timescale 1ns/1ps

module det_evt_src (
    // bench clock
    input wire logic pclk,
    // resting level and pin
    input wire logic idle,
    output logic pin
);
    bit busy = 1'b0;
    initial pin = 1'b0;
    always @(posedge pclk) begin
        if (!busy) begin
            pin <= idle;
        end
    end
    // each level lasts two cycles or more, else the synchroniser may miss it
    task automatic send(input int n, input int w);
        busy = 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 2 * n; i++) begin
            pin <= (i % 2 == 0) ? !idle : idle;
            repeat (w + 2) @(posedge pclk);
        end
        busy = 1'b0;
    endtask
endmodule

// *** sim/det_timer_chk.sv ***
/*
 * Port-level assertions of det_timer.
 * Assumes one pclk domain; bound to every det_timer below.
 */
`timescale 1ns/1ps

module det_timer_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and interrupts
    input wire logic ch1_wave_out,
    input wire logic ch1_wave_oe,
    input wire logic ch2_wave_out,
    input wire logic ch2_wave_oe,
    input wire logic ch1_match_irq,
    input wire logic ch2_match_irq,
    input wire logic irq
);
    // ------------------------------------------------------------
    // mirror of mask and enable bits written over apb
    // ------------------------------------------------------------
    logic wr;
    logic wr_oc;
    logic [1:0] msk_r;
    logic [1:0] oe_r;
    assign wr = psel && penable && pready && pwrite && !pslverr;
    assign wr_oc = wr && paddr == 12'h004;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msk_r <= 2'b00;
            oe_r <= 2'b00;
        end else begin
            msk_r <= (wr && paddr == 12'h024) ? pwdata[1:0] : msk_r;
            oe_r <= wr_oc ? {pwdata[4], pwdata[0]} : oe_r;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer in second access cycle");
    a_err_map: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 12'h024))
        else $error("error flag does not follow address map");
    a_oe_follow: assert property ({ch2_wave_oe, ch1_wave_oe} == oe_r
        || $past(wr_oc))
        else $error("output enable differs from written bit");
    a_wave_toggle: assert property (ch1_match_irq && $past(ch1_wave_oe) && !$past(wr_oc)
        |-> ch1_wave_out != $past(ch1_wave_out))
        else $error("wave did not invert at match");
    a_wave_hold: assert property (!ch1_match_irq && !$past(wr_oc)
        |-> $stable(ch1_wave_out))
        else $error("wave moved without match");
    a_wave2_hold: assert property (!ch2_match_irq && !$past(wr_oc)
        |-> $stable(ch2_wave_out))
        else $error("second wave moved without match");
    a_level_set: assert property (wr_oc && pwdata[3:2] == 2'b01 |=> ch1_wave_out)
        else $error("level set bit ignored");
    // irq is registered from the next mask, so it follows the mirror in the same cycle
    a_irq_masked: assert property (msk_r == 2'b00 |-> !irq)
        else $error("interrupt while all masked");
    a_irq_raise: assert property (ch1_match_irq && msk_r[0] |=> irq)
        else $error("unmasked match gave no interrupt");
    a_match_pulse: assert property (ch1_match_irq |=> !ch1_match_irq)
        else $error("match pulse too long");
    c_wave: cover property (ch1_match_irq && ch1_wave_oe);
    c_err: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
endmodule

bind det_timer det_timer_chk det_timer_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .ch1_wave_out(ch1_wave_out), .ch1_wave_oe(ch1_wave_oe),
    .ch2_wave_out(ch2_wave_out), .ch2_wave_oe(ch2_wave_oe), .ch1_match_irq(ch1_match_irq),
    .ch2_match_irq(ch2_match_irq), .irq(irq));

// *** sim/tb.sv ***
/*
 * Self-checking bench of det_timer: apb registers, divided and event
 * counting, square wave and interrupts.
 * Assumes det_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps

module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [1:0] idle = 2'b00;
    logic [1:0] evt, wave_out, wave_oe, mirq;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 50;
    int mc [2] = '{0, 0};
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        mc[0] += int'(mirq[0] === 1'b1);
        mc[1] += int'(mirq[1] === 1'b1);
    end
    det_timer det_timer_i (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch1_event_in(evt[0]),
        .ch2_event_in(evt[1]), .ch1_wave_out(wave_out[0]), .ch1_wave_oe(wave_oe[0]),
        .ch2_wave_out(wave_out[1]), .ch2_wave_oe(wave_oe[1]), .ch1_match_irq(mirq[0]),
        .ch2_match_irq(mirq[1]), .irq(irq));
    det_evt_src det_evt_src_0 (.pclk(pclk), .idle(idle[0]), .pin(evt[0]));
    det_evt_src det_evt_src_1 (.pclk(pclk), .idle(idle[1]), .pin(evt[1]));
    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            chk(0, 1, "bus wait");
            complete_run();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge keeps a following call off this time step
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk(32'(e), 32'(a > 12'h024), "write error flag");
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, x, "read data");
        chk(32'(e), 32'(a > 12'h024), "read error flag");
    endtask
    function automatic logic sig(input int k);
        return k < 2 ? mirq[k] : wave_out[k - 2];
    endfunction
    function automatic int ex(input int c);
        return c == 15 ? 11 : c - 5;
    endfunction
    // cycles between two match pulses (k 0,1) or two wave edges (k 2,3)
    task automatic interval(input int k, input int x);
        int t;
        logic p;
        logic v;
        t = -1;
        p = sig(k);
        for (int i = 0; i < 3 * x + 64; i++) begin
            @(posedge pclk);
            v = sig(k);
            t = t >= 0 ? t + 1 : t;
            if (k < 2 ? v && !p : v != p) begin
                if (t > 0) begin
                    chk(t, x, "interval");
                    return;
                end
                t = 0;
            end
            p = v;
        end
        chk(0, 1, "event wait");
        complete_run();
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        int s, n, c2;
        int np [2];
        int w [2];
        int base [2];
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i <= 10; i++) begin
            rd(12'(i * 4), 32'h0000_0000);
        end
        d = $random(seed);
        wr(12'h000, d);
        rd(12'h000, d & 32'h0000_00FF);
        wr(12'h02C, d);
        wr(12'h014, d);
        rd(12'h014, 32'h0000_0000);
        wr(12'h004, 32'h0000_00DD);
        rd(12'h004, 32'h0000_0011);
        chk(32'(wave_oe), 32'h0000_0003, "enables");
        chk(32'(wave_out[0]), 32'h0000_0000, "level reset");
        for (int c = 6; c <= 15; c++) begin
            s = $random(seed) & 1;
            n = c < 12 ? $random(seed) & 3 : 0;
            c2 = c == 15 ? 6 : c + 1;
            wr(12'h01C, 0);
            wr(12'h008, s);
            wr(12'h00C, n);
            wr(12'h010, n);
            wr(12'h000, c2 * 16 + c);
            wr(12'h01C, 3);
            interval(0, (n + 1) << (ex(c) + 1 - s));
            interval(1, (n + 1) << (ex(c2) + 1 - s));
        end
        for (int i = 0; i < 2; i++) begin
            n = i * 255;
            wr(12'h01C, 0);
            wr(12'h008, 1);
            wr(12'h000, 32'h0000_0066);
            wr(12'h00C, n);
            wr(12'h010, n);
            wr(12'h004, 32'h0000_0015);
            chk(32'(wave_out[0]), 32'h0000_0001, "level set");
            wr(12'h01C, 3);
            interval(2, (n + 1) * 2);
            interval(3, (n + 1) * 2);
        end
        rd(12'h020, 32'h0000_0003);
        chk(32'(irq), 32'h0000_0000, "masked");
        wr(12'h024, 1);
        @(posedge pclk);
        chk(32'(irq), 32'h0000_0001, "unmasked");
        wr(12'h01C, 0);
        wr(12'h020, 1);
        rd(12'h020, 32'h0000_0002);
        chk(32'(irq), 32'h0000_0000, "cleared");
        wr(12'h024, 3);
        @(posedge pclk);
        chk(32'(irq), 32'h0000_0001, "second unmasked");
        for (int m = 0; m < 2; m++) begin
            wr(12'h01C, 0);
            idle <= 2'b00;
            wr(12'h00C, 2);
            wr(12'h010, 2);
            wr(12'h000, m * 32'h0000_0011);
            wr(12'h01C, 3);
            for (int j = 0; j < 2; j++) begin
                np[j] = 1 + ($random(seed) & 7);
                w[j] = $random(seed) & 3;
                base[j] = mc[j];
            end
            fork
                det_evt_src_0.send(np[0], w[0]);
                det_evt_src_1.send(np[1], w[1]);
            join
            // resting high adds one rising edge, counted only in rising mode
            idle <= 2'b11;
            repeat (8) @(posedge pclk);
            for (int j = 0; j < 2; j++) begin
                chk(mc[j] - base[j], (np[j] + m) / 3, "event matches");
                rd(12'(20 + 4 * j), (np[j] + m) % 3);
            end
        end
        complete_run();
    end
endmodule
